// ### pkg/recorder_map.vh
// What this block does
// - count only instructions retiring at privilege level 3
// - do not count the instruction that enters level 3 from another level
// - count nothing in, entering or leaving system management state
// - put the timestamp counter in records only when the timestamp flag is set
// - wrap flag 0 at start: full ring keeps head, bumps lost count
// - non-wrapping mode resumes storing once software moves the tail
// - wrap flag 1 at start: always store and advance, lost count tallies wraps
// - capability bit tells software whether wrapping mode is supported
// - each retiring instruction decrements every counter whose event it causes
// - cache miss events count only above a programmed minimum latency
// - negative counter starts gathering; it keeps decrementing until the record is written
// - the record describes the instruction that made the counter negative
// - one event serviced at a time; others keep counting and wait
// - a dropped occurrence is gathered from the next causing instruction
// - an aborted replay keeps counting; record comes from the next instruction
// - a complete record is written at head, then head advances
// - full when advanced head equals tail; full bumps the 64-bit lost count
// - only one record reaches the store stage at a time
// - store may finish cycles later; captured data stays exact
// - threshold interrupt when enabled and occupancy exceeds the threshold
// - counters and ring state are software readable and writable for context switch
// - after store or loss reload counter with interval, less overrun below -1
// - tail never modified; current tail used for full and threshold checks
// - reserved and undefined record fields are written as zero
//
// Purpose: register offsets and field positions of the event sample ring recorder
// Assumes: 32-bit apb, one aligned word per register
// Notes: offsets are byte addresses
`ifndef RECORDER_MAP_VH
`define RECORDER_MAP_VH
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_CAP 8'h08
`define OFF_RING_BASE 8'h0c
`define OFF_RING_SLOTS 8'h10
`define OFF_HEAD 8'h14
`define OFF_TAIL 8'h18
`define OFF_THRESH 8'h1c
`define OFF_LOST_LO 8'h20
`define OFF_LOST_HI 8'h24
`define OFF_MIN_LAT 8'h28
`define OFF_INTERVAL 8'h30
`define OFF_COUNT 8'h40
`define CTRL_EN 0
`define CTRL_WRAP 1
`define CTRL_TS 2
`define CTRL_IRQ_EN 3
`define USER_LEVEL 2'h3
`define EV_DMISS 2
`define EV_ID_BASE 8'h02
`define REC_SHIFT 4
`endif

// ### rtl/event_sample_ring_recorder.v
// Purpose: per-thread event counters feeding a ring of sample records in memory
// Assumes: apb slave with no wait states; memory write port with valid/ready
// Notes: record is 128 bits: id, latency, address, timestamp
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "recorder_map.vh"

module event_sample_ring_recorder #(
    parameter NEV = 3,
    parameter CW = 32,
    parameter AW = 32,
    parameter [0:0] WRAP_SUPPORTED = 1'b1
) (
    input wire pclk,
    input wire presetn,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire retire_valid,
    input wire [1:0] retire_priv,
    input wire retire_priv_entry,
    input wire retire_smm,
    input wire retire_smm_switch,
    input wire [NEV-1:0] retire_events,
    input wire [AW-1:0] retire_addr,
    input wire [15:0] retire_miss_lat,
    input wire retire_replay_abort,
    input wire gather_drop,
    input wire [63:0] perf_timestamp_counter,
    output reg mem_wr_valid,
    output reg [AW-1:0] mem_wr_addr,
    output reg [127:0] mem_wr_data,
    input wire mem_wr_ready,
    output reg threshold_irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // next ring slot with wrap at the end of the buffer
    function [31:0] next_slot;
        input [31:0] h;
        input [31:0] n;
        begin
            if (h + 32'h1 >= n) begin
                next_slot = 32'h0;
            end else begin
                next_slot = h + 32'h1;
            end
        end
    endfunction

    // counter reload, keeping any overrun beyond -1
    function [CW-1:0] reload_val;
        input [CW-1:0] iv;
        input [CW-1:0] d;
        begin
            if ($signed(d) < -1) begin
                reload_val = iv + d + {{(CW-1){1'b0}}, 1'b1};
            end else begin
                reload_val = iv;
            end
        end
    endfunction

    // zero-extend or cut a counter-width value to one bus word
    function [31:0] bus_word;
        input [CW-1:0] v;
        reg [CW+31:0] t;
        begin
            t = {32'h0, v};
            bus_word = t[31:0];
        end
    endfunction

    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_STORE = 3'b010;
    localparam [2:0] ST_WRITE = 3'b100;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reg en_r, wrap_cfg_r, ts_en_r, irq_en_r, wrap_active_r;
    reg [31:0] ring_base_r, ring_slots_r, head_r, tail_r, thresh_r;
    reg [63:0] lost_r;
    reg [15:0] min_lat_r;
    reg [CW-1:0] cnt_r [0:NEV-1];
    reg [CW-1:0] interval_r [0:NEV-1];
    reg [2:0] state_r;
    reg [7:0] sel_r;
    reg [127:0] rec_r;
    reg [NEV*CW-1:0] cnt_nxt;
    reg [31:0] rd_data;
    reg rd_ok;
    reg [NEV-1:0] inc;
    reg [7:0] pick;
    reg pick_ok;
    reg [CW-1:0] d;

    wire wr_en = psel & penable & pready & pwrite;
    wire setup = psel & ~penable & ~pready;
    wire [AW+31:0] addr_ext = {32'h0, retire_addr}; // record address field is one word
    wire [31:0] head_next = next_slot(head_r, ring_slots_r);
    wire ring_full = (head_next == tail_r);
    wire [31:0] occ = (head_r >= tail_r) ? head_r - tail_r : head_r + ring_slots_r - tail_r;
    wire reload = ce & (((state_r == ST_STORE) & ring_full & ~wrap_active_r) |
                        ((state_r == ST_WRITE) & mem_wr_ready));

    // eligible retire: user level only, not entering it, never near smm
    wire eligible = en_r & retire_valid & (retire_priv == `USER_LEVEL)
                    & ~retire_priv_entry
                    & ~retire_smm & ~retire_smm_switch;

    // ----------------------------------------------------------------
    // counting and event selection
    // ----------------------------------------------------------------
    // events caused by this retire, with the miss latency filter
    always @* begin : event_inc
        integer i;
        i = 0;
        inc = {NEV{1'b0}};
        for (i = 0; i < NEV; i = i + 1) begin
            inc[i] = eligible & retire_events[i];
            if (i == `EV_DMISS) begin
                inc[i] = inc[i] & (retire_miss_lat > min_lat_r);
            end
        end
    end

    // lowest counter that this instruction drives negative
    always @* begin : event_pick
        integer i;
        i = 0;
        pick = 8'h00;
        pick_ok = 1'b0;
        for (i = NEV - 1; i >= 0; i = i - 1) begin
            d = cnt_r[i] - {{(CW-1){1'b0}}, 1'b1};
            if (inc[i] && d[CW-1]) begin
                pick = i[7:0];
                pick_ok = 1'b1;
            end
        end
        d = {CW{1'b0}};
    end

    // next counter values: reload, software write, or decrement
    always @* begin : count_next
        integer i;
        i = 0;
        cnt_nxt = {NEV*CW{1'b0}};
        for (i = 0; i < NEV; i = i + 1) begin
            cnt_nxt[i*CW +: CW] = cnt_r[i] - {{(CW-1){1'b0}}, inc[i]};
            if (reload && sel_r == i[7:0]) begin
                cnt_nxt[i*CW +: CW] = reload_val(interval_r[i], cnt_nxt[i*CW +: CW]);
            end else if (wr_en && paddr == `OFF_COUNT + 8'h4 * i[7:0]) begin
                cnt_nxt[i*CW +: CW] = pwdata[CW-1:0];
            end
        end
    end

    // counters and intervals
    always @(posedge pclk or negedge presetn) begin : count_regs
        integer i;
        if (!presetn) begin
            for (i = 0; i < NEV; i = i + 1) begin
                cnt_r[i] <= {CW{1'b0}};
                interval_r[i] <= {CW{1'b0}};
            end
        end else if (ce) begin
            for (i = 0; i < NEV; i = i + 1) begin
                cnt_r[i] <= cnt_nxt[i*CW +: CW];
                if (wr_en && paddr == `OFF_INTERVAL + 8'h4 * i[7:0]) begin
                    interval_r[i] <= pwdata[CW-1:0];
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // gather and store sequence
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
            sel_r <= 8'h00;
            rec_r <= 128'h0;
            mem_wr_valid <= 1'b0;
            mem_wr_addr <= {AW{1'b0}};
            mem_wr_data <= 128'h0;
            head_r <= 32'h0;
        end else if (ce) begin
            case (state_r)
                ST_IDLE: begin
                    // capture exact data now; store finishes later
                    if (pick_ok && !gather_drop && !retire_replay_abort) begin
                        sel_r <= pick;
                        rec_r <= {(ts_en_r ? perf_timestamp_counter : 64'h0),
                                  addr_ext[31:0],
                                  (pick == `EV_DMISS) ? retire_miss_lat : 16'h0,
                                  8'h00, pick + `EV_ID_BASE};
                        state_r <= ST_STORE;
                    end
                end
                ST_STORE: begin
                    if (ring_full && !wrap_active_r) begin
                        state_r <= ST_IDLE;
                    end else begin
                        mem_wr_valid <= 1'b1;
                        mem_wr_addr <= ring_base_r[AW-1:0] + {head_r[AW-1-`REC_SHIFT:0], 4'h0};
                        mem_wr_data <= rec_r;
                        state_r <= ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    if (mem_wr_ready) begin
                        mem_wr_valid <= 1'b0;
                        head_r <= head_next;
                        state_r <= ST_IDLE;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
            if (wr_en && paddr == `OFF_HEAD && state_r != ST_WRITE) begin
                head_r <= pwdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r <= 1'b0;
            wrap_cfg_r <= 1'b0;
            ts_en_r <= 1'b0;
            irq_en_r <= 1'b0;
            wrap_active_r <= 1'b0;
            ring_base_r <= 32'h0;
            ring_slots_r <= 32'h0;
            tail_r <= 32'h0;
            thresh_r <= 32'h0;
            min_lat_r <= 16'h0;
            lost_r <= 64'h0;
            threshold_irq <= 1'b0;
        end else if (ce) begin
            if (wr_en) begin
                case (paddr)
                    `OFF_CTRL: begin
                        en_r <= pwdata[`CTRL_EN];
                        wrap_cfg_r <= pwdata[`CTRL_WRAP];
                        ts_en_r <= pwdata[`CTRL_TS];
                        irq_en_r <= pwdata[`CTRL_IRQ_EN];
                        if (pwdata[`CTRL_EN] && !en_r) begin
                            wrap_active_r <= pwdata[`CTRL_WRAP] & WRAP_SUPPORTED;
                        end
                    end
                    `OFF_RING_BASE: ring_base_r <= pwdata;
                    `OFF_RING_SLOTS: ring_slots_r <= pwdata;
                    `OFF_TAIL: tail_r <= pwdata;
                    `OFF_THRESH: thresh_r <= pwdata;
                    `OFF_MIN_LAT: min_lat_r <= pwdata[15:0];
                    `OFF_LOST_LO: lost_r[31:0] <= pwdata;
                    `OFF_LOST_HI: lost_r[63:32] <= pwdata;
                    default: begin
                    end
                endcase
            end
            // lost count: sync-mode misses or wrap-mode wraps; hardware wins
            if ((state_r == ST_STORE && ring_full && !wrap_active_r) ||
                (state_r == ST_WRITE && mem_wr_ready && ring_full && wrap_active_r)) begin
                lost_r <= lost_r + 64'h1;
            end
            threshold_irq <= en_r & irq_en_r & (occ > thresh_r);
        end
    end

    // read mux
    always @* begin : read_mux
        integer i;
        i = 0;
        rd_data = 32'h0;
        rd_ok = 1'b1;
        case (paddr)
            `OFF_CTRL: rd_data = {28'h0, irq_en_r, ts_en_r, wrap_cfg_r, en_r};
            `OFF_STATUS: rd_data = {28'h0, threshold_irq, mem_wr_valid, state_r != ST_IDLE, wrap_active_r};
            `OFF_CAP: rd_data = {31'h0, WRAP_SUPPORTED};
            `OFF_RING_BASE: rd_data = ring_base_r;
            `OFF_RING_SLOTS: rd_data = ring_slots_r;
            `OFF_HEAD: rd_data = head_r;
            `OFF_TAIL: rd_data = tail_r;
            `OFF_THRESH: rd_data = thresh_r;
            `OFF_LOST_LO: rd_data = lost_r[31:0];
            `OFF_LOST_HI: rd_data = lost_r[63:32];
            `OFF_MIN_LAT: rd_data = {16'h0, min_lat_r};
            default: begin
                rd_ok = 1'b0;
                for (i = 0; i < NEV; i = i + 1) begin
                    if (paddr == `OFF_INTERVAL + 8'h4 * i[7:0]) begin
                        rd_data = bus_word(interval_r[i]);
                        rd_ok = 1'b1;
                    end
                    if (paddr == `OFF_COUNT + 8'h4 * i[7:0]) begin
                        rd_data = bus_word(cnt_r[i]);
                        rd_ok = 1'b1;
                    end
                end
            end
        endcase
    end

    // no wait state: answer is ready in the first access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (ce) begin
            pready <= setup;
            if (setup) begin
                prdata <= pwrite ? 32'h0 : rd_data;
                pslverr <= ~rd_ok;
            end else begin
                pslverr <= 1'b0;
            end
        end
    end

endmodule // event_sample_ring_recorder

`default_nettype wire

// ### testbench/recorder_monitor.sv
// Purpose: port-level checks of the event sample ring recorder
// Assumes: clock enable held high while checked
// Notes: bound to the recorder top at the foot of this file
`timescale 1ns/10ps
`default_nettype none
`include "recorder_map.vh"
module recorder_monitor #(
    parameter AW = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic retire_valid,
    input wire logic [1:0] retire_priv,
    input wire logic retire_priv_entry,
    input wire logic retire_smm,
    input wire logic retire_smm_switch,
    input wire logic [AW-1:0] retire_addr,
    input wire logic retire_replay_abort,
    input wire logic gather_drop,
    input wire logic mem_wr_valid,
    input wire logic [AW-1:0] mem_wr_addr,
    input wire logic [127:0] mem_wr_data,
    input wire logic mem_wr_ready
);
// -----------------------------------------
// checks
// -----------------------------------------
default clocking cb @(posedge pclk); endclocking
default disable iff (!presetn);
logic elig;
// retire that may start a record
assign elig = retire_valid && retire_priv == `USER_LEVEL && !retire_priv_entry && !retire_smm
    && !retire_smm_switch && !retire_replay_abort && !gather_drop;
AST_APB_ANSWER: assert property (psel && !penable && ce |=> pready)
    else $error("no answer in access cycle");
AST_APB_ONE: assert property (pready && ce |=> !pready)
    else $error("ready longer than one cycle");
AST_APB_ACCESS: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
AST_APB_ERR_READ: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
    else $error("refused read not zero");
AST_REC_SOURCE: assert property ($rose(mem_wr_valid) |-> $past(elig, 2))
    else $error("record without eligible retire");
AST_REC_ADDR: assert property ($rose(mem_wr_valid) |-> mem_wr_data[63:32] == $past(retire_addr, 2))
    else $error("record address wrong");
AST_REC_HOLD: assert property (mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr)
    && $stable(mem_wr_data)) else $error("record changed while waiting");
AST_REC_RSVD: assert property (mem_wr_valid |-> mem_wr_data[15:8] == 8'h00
    && (mem_wr_data[7:0] == 8'h04 || mem_wr_data[31:16] == 16'h0)) else $error("reserved bits set");
AST_REC_ONE: assert property (mem_wr_valid && mem_wr_ready |=> !mem_wr_valid)
    else $error("write not released");
COV_STORE: cover property ($rose(mem_wr_valid));
COV_STALL: cover property (mem_wr_valid && !mem_wr_ready ##1 mem_wr_ready);
COV_ERR: cover property (pslverr);
endmodule // recorder_monitor
bind event_sample_ring_recorder recorder_monitor #(.AW(AW)) mon (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .retire_valid(retire_valid), .retire_priv(retire_priv), .retire_priv_entry(retire_priv_entry),
    .retire_smm(retire_smm), .retire_smm_switch(retire_smm_switch), .retire_addr(retire_addr),
    .retire_replay_abort(retire_replay_abort), .gather_drop(gather_drop), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));
`default_nettype wire

// ### testbench/ring_memory.sv
// Purpose: application memory taking ring records
// Assumes: one write in flight at a time
// Notes: slow makes it stall four cycles per write
`timescale 1ns/10ps
`default_nettype none
module ring_memory (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic mem_wr_valid,
    input wire logic [31:0] mem_wr_addr,
    input wire logic [127:0] mem_wr_data,
    output logic mem_wr_ready,
    output logic [31:0] wr_count,
    output logic [31:0] last_addr,
    output logic [127:0] last_data
);
logic [2:0] wait_r;
// accept one record, keep the last one for the bench
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        {mem_wr_ready, wait_r, wr_count, last_addr, last_data} <= '0;
    end else if (mem_wr_valid && mem_wr_ready) begin
        wr_count <= wr_count + 32'h1;
        last_addr <= mem_wr_addr;
        last_data <= mem_wr_data;
        mem_wr_ready <= 1'b0;
        wait_r <= 3'h0;
    end else if (mem_wr_valid) begin
        wait_r <= wait_r + 3'h1;
        mem_wr_ready <= !slow || wait_r == 3'h3;
    end
end
endmodule // ring_memory
`default_nettype wire

// ### testbench/tb_event_sample_ring_recorder.sv
// Purpose: self-checking bench for the event sample ring recorder
// Assumes: four ring slots, clock enable held high
// Notes: random retires from a fixed seed
`timescale 1ns/10ps
`default_nettype none
`include "recorder_map.vh"
module tb_event_sample_ring_recorder;
logic pclk, presetn, psel, penable, pwrite, retire_valid, retire_priv_entry, retire_smm, retire_smm_switch;
logic retire_replay_abort, slow, err, tsen, wrap, gather_drop;
logic [1:0] retire_priv, rp;
logic [2:0] retire_events;
logic [3:0] rf;
logic [7:0] paddr;
logic [15:0] retire_miss_lat;
logic [31:0] pwdata, retire_addr, rd, seed, base, head, tail, exp_wr;
logic [63:0] perf_timestamp_counter, lost;
wire [31:0] prdata, mem_wr_addr, wr_count, last_addr;
wire [127:0] mem_wr_data, last_data;
wire pready, pslverr, mem_wr_valid, mem_wr_ready, threshold_irq;
int mismatches, total_checks, cyc, i;
event_sample_ring_recorder dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .retire_valid(retire_valid), .retire_priv(retire_priv), .retire_priv_entry(retire_priv_entry),
    .retire_smm(retire_smm), .retire_smm_switch(retire_smm_switch), .retire_events(retire_events),
    .retire_addr(retire_addr), .retire_miss_lat(retire_miss_lat), .retire_replay_abort(retire_replay_abort),
    .gather_drop(gather_drop), .perf_timestamp_counter(perf_timestamp_counter), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
    .threshold_irq(threshold_irq));
ring_memory mem (.pclk(pclk), .presetn(presetn), .slow(slow), .mem_wr_valid(mem_wr_valid),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready),
    .wr_count(wr_count), .last_addr(last_addr), .last_data(last_data));
// -----------------------------------------
// helpers
// -----------------------------------------
task chk(input logic [127:0] seen, input logic [127:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
        mismatches++;
        $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
endtask
task summarize;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
endtask
task rdc(input logic [7:0] a, input logic [31:0] e, input string what);
    apb(1'b0, a, 32'h0);
    chk(rd, e, what);
endtask
function logic [127:0] rec(input logic [15:0] l, input logic [7:0] id);
    rec = {tsen ? perf_timestamp_counter : 64'h0, retire_addr, id == 8'h04 ? l : 16'h0, 8'h00, id};
endfunction
// one retire, then the store expected by the ring bookkeeping
task ev(input logic [1:0] pr, input logic [3:0] fl, input logic [2:0] e, input logic [15:0] l,
        input logic hit, input logic [7:0] id);
    retire_addr <= $random(seed);
    perf_timestamp_counter <= {$random(seed), $random(seed)};
    slow <= $random(seed);
    retire_priv <= pr;
    {retire_priv_entry, retire_smm, retire_smm_switch, retire_replay_abort} <= fl;
    retire_events <= e;
    retire_miss_lat <= l;
    retire_valid <= 1'b1;
    @(posedge pclk);
    retire_valid <= 1'b0;
    repeat (14) @(posedge pclk);
    if (hit) begin
        if ((head + 1) % 4 == tail) lost++;
        if ((head + 1) % 4 != tail || wrap) begin
            exp_wr++;
            chk(last_addr, base + head * 16, "record address");
            chk(last_data, rec(l, id), "record data");
            head = (head + 1) % 4;
        end
    end
    chk(wr_count, exp_wr, "store count");
endtask
initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
end
// hang guard
always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
        mismatches++;
        summarize();
    end
end
// -----------------------------------------
// scenarios
// -----------------------------------------
initial begin
    {psel, penable, pwrite, retire_valid, retire_priv_entry, retire_smm, retire_smm_switch} = '0;
    {gather_drop, retire_replay_abort, slow, retire_priv, retire_events, paddr, pwdata, retire_addr} = '0;
    {retire_miss_lat, perf_timestamp_counter, lost, exp_wr, head, tail} = '0;
    {seed, base, tsen, wrap, presetn} = {32'd65517, 32'h1000, 3'b100};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`OFF_CAP, 32'h1, "capability");
    rdc(8'hfc, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    wr(8'hfc, 32'h1);
    chk(err, 1'b1, "unmapped write error");
    wr(`OFF_RING_BASE, base);
    wr(`OFF_RING_SLOTS, 32'h4);
    wr(`OFF_COUNT + 8'h04, 32'h7fffffff);
    wr(`OFF_COUNT + 8'h08, 32'h7fffffff);
    wr(`OFF_CTRL, 32'h5);
    for (i = 0; i < 4; i++) ev(i == 0 ? 2'h0 : 2'h3, 4'h1 << i, 3'b001, 16'h0, 1'b0, 8'h0);
    rdc(`OFF_COUNT, 32'h0, "count untouched");
    for (i = 0; i < 4; i++) ev(2'h3, 4'h0, 3'b001, 16'h0, 1'b1, 8'h02);
    rdc(`OFF_LOST_LO, lost[31:0], "lost count");
    rdc(`OFF_HEAD, head, "head kept");
    tail = 2;
    wr(`OFF_TAIL, tail);
    ev(2'h3, 4'h0, 3'b001, 16'h0, 1'b1, 8'h02);
    rdc(`OFF_TAIL, 32'h2, "tail kept");
    wr(`OFF_THRESH, 32'h1);
    wr(`OFF_CTRL, 32'hd);
    repeat (2) @(posedge pclk);
    chk(threshold_irq, 1'b1, "irq above");
    wr(`OFF_THRESH, 32'h2);
    repeat (2) @(posedge pclk);
    chk(threshold_irq, 1'b0, "irq at threshold");
    $display("test sync ring finished");
    tail = 0;
    wr(`OFF_TAIL, tail);
    wr(`OFF_MIN_LAT, 32'd100);
    wr(`OFF_COUNT + 8'h04, 32'h0);
    wr(`OFF_COUNT + 8'h08, 32'h0);
    ev(2'h3, 4'h0, 3'b111, 16'd100, 1'b1, 8'h02);
    ev(2'h3, 4'h0, 3'b010, 16'h0, 1'b1, 8'h03);
    ev(2'h3, 4'h0, 3'b100, 16'd101, 1'b1, 8'h04);
    $display("test events finished");
    wr(`OFF_CTRL, 32'h0);
    {head, tail, lost, tsen, wrap} = {96'h0, 64'h0, 2'b01};
    wr(`OFF_HEAD, 32'h0);
    wr(`OFF_TAIL, 32'h0);
    wr(`OFF_LOST_LO, 32'h0);
    wr(`OFF_LOST_HI, 32'h0);
    wr(`OFF_CTRL, 32'h3);
    for (i = 0; i < 24; i++) begin
        rp = $random(seed) | 2'h2;
        rf = $random(seed);
        if (rf[3]) rf = 4'h0;
        ev(rp, rf, 3'b001, 16'h0, rp == 2'h3 && rf == 4'h0, 8'h02);
    end
    wr(`OFF_CTRL, 32'h0);
    rdc(`OFF_LOST_LO, lost[31:0], "wrap count low");
    rdc(`OFF_LOST_HI, lost[63:32], "wrap count high");
    rdc(`OFF_HEAD, head, "wrap head");
    rdc(`OFF_STATUS, 32'h1, "status wrap latched");
    $display("test wrap ring finished");
    {head, tail, wrap, tsen} = {64'h0, 2'b01};
    wr(`OFF_HEAD, 32'h0);
    wr(`OFF_INTERVAL, 32'h5);
    wr(`OFF_COUNT, 32'h0);
    wr(`OFF_CTRL, 32'h5);
    ev(2'h3, 4'h1, 3'b001, 16'h0, 1'b0, 8'h0);
    gather_drop <= 1'b1;
    ev(2'h3, 4'h0, 3'b001, 16'h0, 1'b0, 8'h0);
    gather_drop <= 1'b0;
    ev(2'h3, 4'h0, 3'b001, 16'h0, 1'b1, 8'h02);
    rdc(`OFF_COUNT, 32'h3, "reload less overrun");
    rdc(`OFF_CTRL, 32'h5, "control readback");
    $display("test reload finished");
    summarize();
end
endmodule // tb_event_sample_ring_recorder
`default_nettype wire
